// file: cfgsq_consts.svh
// Constants of the configuration sequence controller
`ifndef CFGSQ_CONSTS_SVH
`define CFGSQ_CONSTS_SVH
// APB register byte offsets
`define CFGSQ_CTRL_OFS 12'h000
`define CFGSQ_STAT_OFS 12'h004
`define CFGSQ_SCHM_OFS 12'h008
`define CFGSQ_BITS_OFS 12'h00C
// Control fields
`define CFGSQ_CTRL_AUTO_BIT 0
`define CFGSQ_CTRL_USRCLK_BIT 1
`define CFGSQ_CTRL_INITDONE_BIT 2
`define CFGSQ_CTRL_SECURE_BIT 3
`define CFGSQ_CTRL_NARROW_BIT 4
`define CFGSQ_CTRL_JTAG_BIT 5
`define CFGSQ_CTRL_RST 6'h00
// First-frame bit that turns the init-done pin on
`define CFGSQ_FRAME_INITDONE_BIT 0
`define CFGSQ_BITS_RST 32'h0000_0400
// Timing
`define CFGSQ_CLK_MHZ 100
`define CFGSQ_TIMEOUT_NS 230000
`define CFGSQ_TIMEOUT_CYC ((`CFGSQ_TIMEOUT_NS * `CFGSQ_CLK_MHZ) / 1000)
`define CFGSQ_OSC_MHZ 10
`define CFGSQ_OSC_DIV (`CFGSQ_CLK_MHZ / `CFGSQ_OSC_MHZ)
`define CFGSQ_INIT_BASE 3185
`define CFGSQ_INIT_SECURE 3192
`endif

// file: cfgsq_host_model.sv
// Behavioural configuration host driving the link pins
`timescale 1ns/100ps
`default_nettype none
module cfgsq_host_model (
  input wire logic pclk,
  output logic config_clock,
  output logic [15:0] config_data,
  output logic config_request_n
);
  initial begin
    config_clock = 1'b0;
    config_data = 16'hA5A5;
    config_request_n = 1'b1;
  end
  // ====
  // Link tasks
  // Clock idles low between frames; data flips so stale values never match
  task automatic send(input int cnt, input logic [15:0] first);
    for (int i = 0; i < cnt; i++) begin
      @(posedge pclk);
      config_data <= (i == 0) ? first : {i[7:0], ~i[7:0]};
      repeat (3) @(posedge pclk);
      config_clock <= 1'b1;
      repeat (4) @(posedge pclk);
      config_clock <= 1'b0;
    end
    @(posedge pclk);
    config_data <= ~config_data;
  endtask
  // caller holds low at least 500 ns
  task automatic req(input logic v);
    @(posedge pclk);
    config_request_n <= v;
  endtask
endmodule
`default_nettype wire

// file: cfgsq_monitor.sv
// Assertion checker for the configuration sequence controller
`timescale 1ns/100ps
`default_nettype none
module cfgsq_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic config_request_n,
  input wire logic config_status_n_oe,
  input wire logic config_complete_oe,
  input wire logic config_complete_in,
  input wire logic init_done_oe,
  input wire logic user_io_oe,
  input wire logic weak_pullup_en,
  input wire logic user_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // Properties
  // Request pin passes a two-stage synchroniser
  sequence s_req_low;
    !config_request_n [*4];
  endsequence
  sequence s_req_recent;
    !$past(config_request_n, 3) || !$past(config_request_n, 4) || !$past(config_request_n, 5);
  endsequence
  property p_req_reset;
    s_req_low |-> config_status_n_oe && config_complete_oe && !user_io_oe;
  endproperty
  a_req_reset: assert property (p_req_reset) else $error("request low without reset outputs");
  property p_err_complete;
    config_status_n_oe |-> config_complete_oe;
  endproperty
  a_err_complete: assert property (p_err_complete) else $error("complete freed while status low");
  property p_user_out;
    user_mode |-> user_io_oe && !weak_pullup_en && !init_done_oe;
  endproperty
  a_user_out: assert property (p_user_out) else $error("user mode outputs wrong");
  property p_user_entry;
    $rose(user_mode) |-> config_complete_in && !$past(config_complete_oe, 8);
  endproperty
  a_user_entry: assert property (p_user_entry) else $error("user mode before complete");
  property p_user_leave;
    $fell(user_mode) |-> s_req_recent;
  endproperty
  a_user_leave: assert property (p_user_leave) else $error("user mode left without request");
  property p_initdone;
    $fell(init_done_oe) |-> (user_mode || config_status_n_oe || $past(config_status_n_oe)) or s_req_recent;
  endproperty
  a_initdone: assert property (p_initdone) else $error("init done freed early");
  property p_unmapped;
    psel && penable && paddr > 12'h00C |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_ready;
    psel |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bus wait state seen");
endmodule
bind cfgsq_top cfgsq_monitor u_mon (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .config_request_n, .config_status_n_oe, .config_complete_oe, .config_complete_in, .init_done_oe,
  .user_io_oe, .weak_pullup_en, .user_mode);
`default_nettype wire

// file: cfgsq_pkg.sv
// Types of the configuration sequence controller
package cfgsq_pkg;
  typedef enum logic [2:0] {
    CFGSQ_RESET = 3'b000,
    CFGSQ_CONFIG = 3'b001,
    CFGSQ_INIT = 3'b011,
    CFGSQ_USER = 3'b010,
    CFGSQ_ERROR = 3'b110
  } cfgsq_state_t;
  typedef enum logic [2:0] {
    CFGSQ_SCH_NONE = 3'h0,
    CFGSQ_SCH_AS = 3'h1,
    CFGSQ_SCH_AP = 3'h2,
    CFGSQ_SCH_PS = 3'h3,
    CFGSQ_SCH_FPP = 3'h4,
    CFGSQ_SCH_FPP_ENC = 3'h5,
    CFGSQ_SCH_JTAG = 3'h6
  } cfgsq_scheme_t;
  typedef struct packed {
    cfgsq_scheme_t scheme;
    logic fast_por;
  } cfgsq_decode_t;
  typedef struct packed {
    logic jtag;
    logic narrow;
    logic secure;
    logic init_done_en;
    logic user_clk;
    logic auto_restart;
  } cfgsq_ctrl_t;
endpackage

// file: cfgsq_top.sv
// Configuration sequence controller with APB control
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cfgsq_consts.svh"

module cfgsq_top
  import cfgsq_pkg::*;
#(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned TIMEOUT_CYC = `CFGSQ_TIMEOUT_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic config_clock,
  input wire logic [DATA_W-1:0] config_data,
  input wire logic frame_error,
  input wire logic config_request_n,
  input wire logic config_status_n_in,
  output logic config_status_n_out,
  output logic config_status_n_oe,
  input wire logic config_complete_in,
  output logic config_complete_out,
  output logic config_complete_oe,
  input wire logic user_startup_clock,
  input wire logic [3:0] scheme_select,
  output logic init_done_out,
  output logic init_done_oe,
  output logic user_io_oe,
  output logic weak_pullup_en,
  output logic user_mode
);

  // Data narrower than a parallel word, or a timeout past the 24-bit counter, cannot be served
  if (DATA_W < 16 || TIMEOUT_CYC < 2 || TIMEOUT_CYC > 32'h00FF_FFFF) begin : g_param_check
    $error("cfgsq_top: unsupported parameter value");
  end

  // ==========================================================
  // Scheme decode
  // decode table, with folded in
  function automatic cfgsq_decode_t decode_scheme(input logic [3:0] sel, input logic secure,
                                                  input logic narrow, input logic jtag);
    cfgsq_decode_t d;
    logic [3:0] s;
    d = '{scheme: CFGSQ_SCH_NONE, fast_por: 1'b0};
    s = narrow ? {1'b0, sel[2:0]} : sel;
    if (jtag) begin
      d.scheme = CFGSQ_SCH_JTAG;
    end else begin
      case (s)
        4'h2, 4'h3: d.scheme = CFGSQ_SCH_AS;
        4'hD: d = '{scheme: CFGSQ_SCH_AS, fast_por: 1'b1};
        4'h4: d = '{scheme: narrow ? CFGSQ_SCH_NONE : CFGSQ_SCH_AS, fast_por: 1'b1};
        4'h7, 4'hB, 4'h8: d.scheme = (secure || narrow) ? CFGSQ_SCH_NONE : CFGSQ_SCH_AP;
        4'h5, 4'h6: begin
          if (secure) begin
            d = '{scheme: CFGSQ_SCH_FPP_ENC, fast_por: 1'b1};
          end else if (!narrow) begin
            d = '{scheme: CFGSQ_SCH_AP, fast_por: 1'b1};
          end
        end
        4'h0: d.scheme = CFGSQ_SCH_PS;
        4'hC: d = '{scheme: CFGSQ_SCH_PS, fast_por: 1'b1};
        4'hE: d = '{scheme: CFGSQ_SCH_FPP, fast_por: 1'b1};
        4'hF: d = '{scheme: secure ? CFGSQ_SCH_NONE : CFGSQ_SCH_FPP, fast_por: 1'b1};
        4'h1: d = '{scheme: secure ? CFGSQ_SCH_FPP : CFGSQ_SCH_NONE, fast_por: secure};
        default: d.scheme = CFGSQ_SCH_NONE;
      endcase
    end
    return d;
  endfunction

  function automatic logic [4:0] bits_per_clock(input cfgsq_scheme_t sch);
    case (sch)
      CFGSQ_SCH_AP: return 5'd16;
      CFGSQ_SCH_FPP, CFGSQ_SCH_FPP_ENC: return 5'd8;
      default: return 5'd1;
    endcase
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [6:0] sync1_ff;
  logic [6:0] sync2_ff;
  logic [6:0] sync_prev_ff;
  logic [DATA_W-1:0] data1_ff;
  logic [DATA_W-1:0] data2_ff;
  logic [3:0] sel1_ff;
  logic [3:0] sel2_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle pin levels: request and status high; marker bit 0 low
      sync1_ff <= 7'h22;
      sync2_ff <= 7'h22;
      sync_prev_ff <= 7'h22;
      data1_ff <= '0;
      data2_ff <= '0;
      sel1_ff <= 4'h0;
      sel2_ff <= 4'h0;
    end else begin
      sync1_ff <= {config_complete_in, config_status_n_in, frame_error, user_startup_clock,
                   config_clock, config_request_n, 1'b1};
      sync2_ff <= sync1_ff;
      sync_prev_ff <= sync2_ff;
      data1_ff <= config_data;
      data2_ff <= data1_ff;
      sel1_ff <= scheme_select;
      sel2_ff <= sel1_ff;
    end
  end

  wire req_n_s = sync2_ff[1];
  wire cclk_rise = sync2_ff[2] & ~sync_prev_ff[2];
  wire uclk_rise = sync2_ff[3] & ~sync_prev_ff[3];
  wire ferr_s = sync2_ff[4];
  wire status_pin_s = sync2_ff[5];
  // Complete wire read as a level: only INIT looks, entered after release

  // ==========================================================
  // Registers and state
  cfgsq_ctrl_t ctrl_ff;
  logic [31:0] total_bits_ff;
  cfgsq_state_t state_ff;
  cfgsq_state_t nxt_state;
  logic [31:0] bit_cnt_ff;
  logic [31:0] nxt_bit_cnt;
  logic [23:0] tmo_ff;
  logic [23:0] nxt_tmo;
  logic [11:0] init_cnt_ff;
  logic [11:0] nxt_init_cnt;
  logic [3:0] osc_ff;
  logic init_done_en_ff;
  logic first_frame_ff;
  logic [3:0] strap_ff;
  logic strap_valid_ff;
  logic [7:0] err_cnt_ff;

  cfgsq_decode_t dec;
  assign dec = decode_scheme(strap_ff, ctrl_ff.secure, ctrl_ff.narrow, ctrl_ff.jtag);
  wire [4:0] width = bits_per_clock(dec.scheme);
  wire [11:0] init_need = ctrl_ff.secure ? 12'(`CFGSQ_INIT_SECURE) : 12'(`CFGSQ_INIT_BASE);
  // internal oscillator tick from pclk divider
  wire osc_tick = (osc_ff == 4'(`CFGSQ_OSC_DIV - 1));
  // start-up clock only counted in init state
  wire init_tick = ctrl_ff.user_clk ? uclk_rise : osc_tick;

  // ==========================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_tmo = tmo_ff;
    nxt_init_cnt = init_cnt_ff;
    case (state_ff)
      CFGSQ_RESET: begin
        nxt_bit_cnt = '0;
        nxt_init_cnt = '0;
        // start once request high and status line seen released
        // Straps read as zero, a valid code, until latched
        if (strap_valid_ff && req_n_s && status_pin_s && dec.scheme != CFGSQ_SCH_NONE) begin
          nxt_state = CFGSQ_CONFIG;
        end
      end
      CFGSQ_CONFIG: begin
        if (ferr_s) begin
          nxt_state = CFGSQ_ERROR;
          nxt_tmo = '0;
        end else if (cclk_rise) begin
          nxt_bit_cnt = bit_cnt_ff + 32'(width);
          // released complete line, then wait for its rise
          if (nxt_bit_cnt >= total_bits_ff) begin
            nxt_state = CFGSQ_INIT;
          end
        end
      end
      CFGSQ_INIT: begin
        // count initialization cycles after complete rises
        if (init_tick && (init_cnt_ff != '0 || sync2_ff[6])) begin
          nxt_init_cnt = init_cnt_ff + 12'h001;
          if (nxt_init_cnt == init_need) begin
            nxt_state = CFGSQ_USER;
          end
        end
      end
      CFGSQ_USER: nxt_state = CFGSQ_USER;
      CFGSQ_ERROR: begin
        // Counter cleared on each error entry, so every retry waits in full
        // bounded timeout then self retry
        if (ctrl_ff.auto_restart) begin
          nxt_tmo = tmo_ff + 24'h000001;
          if (nxt_tmo >= 24'(TIMEOUT_CYC)) begin
            nxt_state = CFGSQ_RESET;
          end
        end
      end
      default: nxt_state = CFGSQ_RESET;
    endcase
    // request low forces reset; return path
    if (!req_n_s) begin
      nxt_state = CFGSQ_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= CFGSQ_RESET;
      bit_cnt_ff <= '0;
      tmo_ff <= '0;
      init_cnt_ff <= '0;
      osc_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      tmo_ff <= nxt_tmo;
      init_cnt_ff <= nxt_init_cnt;
      osc_ff <= osc_tick ? 4'h0 : osc_ff + 4'h1;
    end
  end

  // Marker trails the sync chain, so straps are settled when taken
  // straps caught once after reset release, held static
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_ff <= 4'h0;
      strap_valid_ff <= 1'b0;
    end else if (!strap_valid_ff) begin
      strap_ff <= sel2_ff;
      strap_valid_ff <= sync2_ff[0];
    end
  end

  // option bit loads from first frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_en_ff <= 1'b0;
      first_frame_ff <= 1'b1;
      err_cnt_ff <= 8'h00;
    end else begin
      if (state_ff == CFGSQ_RESET) begin
        init_done_en_ff <= 1'b0;
        first_frame_ff <= 1'b1;
      end else if (state_ff == CFGSQ_CONFIG && cclk_rise && first_frame_ff) begin
        init_done_en_ff <= ctrl_ff.init_done_en & data2_ff[`CFGSQ_FRAME_INITDONE_BIT];
        first_frame_ff <= 1'b0;
      end
      if (state_ff == CFGSQ_CONFIG && nxt_state == CFGSQ_ERROR && err_cnt_ff != 8'hFF) begin
        err_cnt_ff <= err_cnt_ff + 8'h01;
      end
    end
  end

  // ==========================================================
  // Pins
  wire in_cfg_done = (state_ff == CFGSQ_INIT) || (state_ff == CFGSQ_USER);
  // Open-drain pins: only the enables move, the level is always low
  // status driven low in error, and in reset while request is low
  assign config_status_n_out = 1'b0;
  assign config_status_n_oe = (state_ff == CFGSQ_RESET && !req_n_s) || (state_ff == CFGSQ_ERROR);
  // open-drain complete released only after all bits
  assign config_complete_out = 1'b0;
  assign config_complete_oe = !in_cfg_done;
  assign init_done_out = 1'b0;
  assign init_done_oe = init_done_en_ff && (state_ff != CFGSQ_USER) && (state_ff != CFGSQ_RESET);
  // user I/O live, pull-ups off in user mode
  assign user_mode = (state_ff == CFGSQ_USER);
  assign user_io_oe = user_mode;
  assign weak_pullup_en = !user_mode;

  // ==========================================================
  // APB slave, zero wait
  wire wr = psel & penable & pwrite;
  wire hit_ctrl = (paddr == `CFGSQ_CTRL_OFS);
  wire hit_stat = (paddr == `CFGSQ_STAT_OFS);
  wire hit_schm = (paddr == `CFGSQ_SCHM_OFS);
  wire hit_bits = (paddr == `CFGSQ_BITS_OFS);
  wire hit_any = hit_ctrl | hit_stat | hit_schm | hit_bits;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= cfgsq_ctrl_t'(`CFGSQ_CTRL_RST);
      total_bits_ff <= `CFGSQ_BITS_RST;
    end else if (wr && hit_ctrl) begin
      ctrl_ff <= cfgsq_ctrl_t'(pwdata[5:0]);
    end else if (wr && hit_bits) begin
      total_bits_ff <= pwdata;
    end
  end

  wire [31:0] stat_word = {err_cnt_ff, 12'h000, init_cnt_ff};
  wire [31:0] schm_word = {20'h00000, strap_ff, dec.fast_por, dec.scheme, 1'b0, state_ff};
  // Unmapped addresses answer with an error; writes to them are dropped
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (hit_ctrl) prdata = {26'h0000000, ctrl_ff};
      if (hit_stat) prdata = stat_word;
      if (hit_schm) prdata = schm_word;
      if (hit_bits) prdata = total_bits_ff;
    end
  end

endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench of the configuration sequence controller
`timescale 1ns/100ps
`default_nettype none
`include "cfgsq_consts.svh"
module tb_top;
  import cfgsq_pkg::*;
  localparam int TO = 20;
  localparam logic [63:0] DEC = 64'hCC9B2002_2AA91103;
  localparam logic [3:0] VS [5] = '{4'h4, 4'h7, 4'h5, 4'h1, 4'h0};
  localparam logic [5:0] VC [5] = '{6'h10, 6'h10, 6'h08, 6'h08, 6'h20};
  localparam cfgsq_scheme_t VE [5] = '{CFGSQ_SCH_NONE, CFGSQ_SCH_NONE, CFGSQ_SCH_FPP_ENC, CFGSQ_SCH_FPP, CFGSQ_SCH_JTAG};
  logic pclk, presetn, psel, penable, pwrite, frame_error, ustart, urun, cc, pready, pslverr, er;
  logic cfg_clk, req_n, st_out, st_oe, cd_out, cd_oe, id_out, id_oe, io_oe, pu_en, umode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cfg_data;
  logic [3:0] strap;
  int n_fail = 0, total_checks = 0, cyc = 0, n, k;
  wire st_wire = ~st_oe;
  wire cd_wire = ~cd_oe;
  cfgsq_top #(.DATA_W(16), .TIMEOUT_CYC(TO)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .config_clock(cfg_clk), .config_data(cfg_data), .frame_error(frame_error),
    .config_request_n(req_n), .config_status_n_in(st_wire), .config_status_n_out(st_out),
    .config_status_n_oe(st_oe), .config_complete_in(cd_wire), .config_complete_out(cd_out),
    .config_complete_oe(cd_oe), .user_startup_clock(ustart), .scheme_select(strap), .init_done_out(id_out),
    .init_done_oe(id_oe), .user_io_oe(io_oe), .weak_pullup_en(pu_en), .user_mode(umode));
  cfgsq_host_model u_host (.pclk(pclk), .config_clock(cfg_clk), .config_data(cfg_data), .config_request_n(req_n));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cc <= urun ? ~cc : cc;
    ustart <= (urun && cc) ? ~ustart : ustart;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      final_report();
    end
  end
  // ====
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input logic [3:0] s);
    presetn <= 1'b0;
    strap <= s;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic wt(input int sel, input int lim);
    logic up;
    up = ustart;
    n = 0;
    k = 0;
    while (n < lim && !(sel == 0 ? cd_oe === 1'b0 : sel == 1 ? umode === 1'b1 : st_oe === 1'b0)) begin
      @(posedge pclk);
      n++;
      k += (ustart === 1'b1 && up === 1'b0);
      up = ustart;
    end
  endtask
  task automatic go(input logic [31:0] ctl);
    rst(4'h0);
    apb(1'b1, `CFGSQ_BITS_OFS, 32'h0000_0010);
    apb(1'b1, `CFGSQ_CTRL_OFS, ctl);
  endtask
  task automatic state_is_config();
    apb(1'b0, `CFGSQ_SCHM_OFS, 32'h0);
    chk("state", {29'h0, rd[2:0]}, {29'h0, CFGSQ_CONFIG});
  endtask
  // ====
  // Scenarios
  task automatic t_regs();
    rst(4'h0);
    apb(1'b0, `CFGSQ_BITS_OFS, 32'h0);
    chk("bits reset", rd, `CFGSQ_BITS_RST);
    apb(1'b1, `CFGSQ_CTRL_OFS, 32'h0000_003F);
    apb(1'b0, `CFGSQ_CTRL_OFS, 32'h0);
    chk("ctrl rw", rd, 32'h0000_003F);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk("unmapped err", {31'h0, er}, 32'h1);
  endtask
  task automatic t_decode();
    for (int c = 0; c < 16; c++) begin
      rst(c[3:0]);
      apb(1'b0, `CFGSQ_SCHM_OFS, 32'h0);
      chk("scheme", {29'h0, rd[6:4]}, {29'h0, DEC[4*c+:3]});
      if (DEC[4*c+:3] != 3'h0) chk("fast por", {31'h0, rd[7]}, {31'h0, DEC[4*c+3]});
    end
    for (int i = 0; i < 5; i++) begin
      rst(VS[i]);
      apb(1'b1, `CFGSQ_CTRL_OFS, {26'h0, VC[i]});
      apb(1'b0, `CFGSQ_SCHM_OFS, 32'h0);
      chk("variant", {29'h0, rd[6:4]}, {29'h0, VE[i]});
    end
  endtask
  task automatic t_flow(input logic [31:0] ctl, input int lo, input int hi);
    go(ctl);
    state_is_config();
    urun <= 1'b1;
    u_host.send(15, 16'h0001);
    chk("init done low", {31'h0, id_oe}, 32'h1);
    chk("complete held", {31'h0, cd_oe}, 32'h1);
    u_host.send(1, 16'h0000);
    wt(0, 10);
    chk("complete freed", {31'h0, cd_oe}, 32'h0);
    wt(1, 40000);
    chk("init length", {31'h0, (ctl[1] ? k : n) >= lo && (ctl[1] ? k : n) <= hi}, 32'h1);
    chk("user mode", {29'h0, io_oe, pu_en, id_oe}, 32'h4);
    u_host.req(1'b0);
    repeat (60) @(posedge pclk);
    chk("request reset", {29'h0, st_oe, cd_oe, io_oe}, 32'h6);
    chk("drive levels", {29'h0, st_out, cd_out, id_out}, 32'h0);
    u_host.req(1'b1);
    urun <= 1'b0;
  endtask
  task automatic t_err(input logic [31:0] ctl);
    go(ctl);
    u_host.send(4, 16'h0000);
    frame_error <= 1'b1;
    repeat (3) @(posedge pclk);
    frame_error <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("error pins", {30'h0, st_oe, cd_oe}, 32'h3);
    if (ctl[0]) begin
      wt(2, TO + 10);
      chk("auto release", {31'h0, st_oe}, 32'h0);
    end else begin
      repeat (TO * 5) @(posedge pclk);
      chk("error held", {31'h0, st_oe}, 32'h1);
      u_host.req(1'b0);
      repeat (60) @(posedge pclk);
      u_host.req(1'b1);
    end
    repeat (10) @(posedge pclk);
    state_is_config();
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, frame_error, urun, ustart, cc, presetn} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    strap = 4'h0;
    t_regs();
    t_decode();
    t_flow(32'h0000_0004, 31840, 31870);
    t_flow(32'h0000_000E, 3191, 3195);
    t_err(32'h0);
    t_err(32'h1);
    final_report();
  end
endmodule
`default_nettype wire
